/* File: rtl/vlc_bank.sv */
// Voltage limit command bank with thresholds, set points and checks
`timescale 1ns/1ps

// Operation
// RULE1: Input overvoltage fault when input exceeds threshold
// RULE2: Input undervoltage warning armed after start and enable
// RULE3: Undervoltage warning sets input status bits, alert
// RULE4: Conversion starts at start, stops at stop
// RULE5: Host writes filter resistance, zero if absent
// RULE6: Output format byte is read-only, linear
// RULE7: Commanded output clamped to programmable upper limit
// RULE8: Comparator above fault threshold raises overvoltage fault
// RULE9: Host waits before raising set point after change
// RULE10: Busy computing drives common status bits low
// RULE11: Pull-down response keeps fault pin quiet
// RULE12: Overvoltage forces high gate off, low gate on
// RULE13: Overvoltage warning compares peak reading to threshold
// RULE14: Overvoltage warning sets status bits and alert
// RULE15: Overvoltage warning detection may take 120 ms
// RULE16: Margin high applied when operation selects it
// RULE17: Margin low applied when operation selects it
// RULE18: Set point writes ignored during rise or fall
// RULE19: Steady output ramps to new set point
// RULE20: Nominal set point is unsigned 16-bit word
// RULE21: Fixed read-only absolute ceiling per channel
// RULE22: Nominal above ceiling: fault, clamp, warning bit
// RULE23: Undervoltage warning sets status bits and alert
// RULE24: Output words are mantissa times two-power exponent
// RULE25: Output commands per channel, input commands shared
module vlc_bank
   import vlc_pkg::*;
#(
   parameter int OVF_SETTLE_CYC = VLC_OVF_SETTLE_CYC, // Busy time after threshold change
   parameter int OVW_DETECT_CYC = VLC_OVW_DETECT_CYC, // Warning evaluation interval
   parameter int RAMP_STEP      = 1                   // Set point step per rate tick
)(
   input  wire logic                  clk,
   input  wire logic                  rst,
   input  wire vlc_req_type           req,             // Register access from serial engine
   output logic [15:0]                rd_data,         // Read answer, one cycle after rd
   output logic                       rd_valid,        // Read answer strobe
   input  wire logic [15:0]           vin_meas,        // Measured input, linear 11-bit form
   input  wire vlc_meas_type [1:0]    meas,            // Output measurements per channel
   input  wire logic [1:0]            run_en,          // Unit enable per channel
   input  wire vlc_op_type [1:0]      op_sel,          // Operation selection per channel
   input  wire logic [1:0]            ov_pd_response,  // Response is pull-down or zero
   input  wire logic [1:0]            alert_mask,      // Alert mask per source group
   input  wire logic                  rate_tick,       // Transition rate pacing
   input  wire vlc_phase_type [1:0]   phase,           // Sequencing phase per channel
   output logic                       convert_on,      // Power conversion allowed
   output logic [1:0][15:0]           vout_target,     // Ramped set point per channel
   output logic [1:0]                 high_side_gate_drive,
   output logic [1:0]                 low_side_gate_drive,
   output logic [1:0]                 fault_pin_n,     // Fault pin, low asserted
   output logic                       alert_n,         // Alert line, low asserted
   output logic                       communication_fault,
   output logic [7:0]                 status_byte,
   output logic [15:0]                status_word,
   output logic [7:0]                 status_input,
   output logic [1:0][7:0]            status_vout,
   output logic [7:0]                 common_status_register
);

   // Refuse parameter values the counters cannot serve
   if (OVF_SETTLE_CYC < 1 || OVW_DETECT_CYC < 1 || RAMP_STEP < 1 || RAMP_STEP > 16'hffff)
      $error("vlc_bank: bad timing parameter");

   localparam logic [15:0] STEP = RAMP_STEP[15:0];

   // Per-channel output registers
   logic [1:0][15:0] nom_q, upper_q, mhi_q, mlo_q, ovf_q, ovw_q, uvw_q, uvf_q;
   // Shared input registers
   logic [15:0] in_start_q, in_stop_q, in_ovf_q, in_uvw_q, in_filt_q;
   logic        conv_q;          // Conversion running
   logic [1:0]  uv_arm_q;        // Input warning armed per channel
   logic [31:0] busy_cnt_q;      // Threshold settle counter
   logic [31:0] ovw_cnt_q;       // Warning evaluation interval counter
   logic [1:0][15:0] tgt_q;      // Ramped target per channel
   logic [1:0]  ovf_q_flag, ovw_flag, uvw_flag, maxw_flag;
   logic        in_ovf_flag, in_uvw_flag, cml_q;

   // Compare two linear 5s/11s words as real values
   function automatic logic l11_gt(input logic [15:0] a, input logic [15:0] b);
      logic signed [4:0] ea, eb;
      logic signed [41:0] va, vb;
      ea = a[15:11];
      eb = b[15:11];
      va = 42'(signed'(a[10:0])) <<< (5'(ea + 5'sd16));
      vb = 42'(signed'(b[10:0])) <<< (5'(eb + 5'sd16));
      return va > vb;
   endfunction

   // Output words share the channel exponent, so plain unsigned compare holds (see RULE24)
   function automatic logic [15:0] min16(input logic [15:0] a, input logic [15:0] b);
      return (a < b) ? a : b;
   endfunction

   wire wr_any = req.wr;
   wire pg = req.page;

   // Writes to output registers, page selects channel (see RULE25)
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         for (int c = 0; c < 2; c++) begin
            nom_q[c]   <= VLC_RST_OUT_NOM;
            upper_q[c] <= VLC_RST_OUT_UPPER;
            mhi_q[c]   <= VLC_RST_OUT_MHI;
            mlo_q[c]   <= VLC_RST_OUT_MLO;
            ovf_q[c]   <= VLC_RST_OUT_OVF;
            ovw_q[c]   <= VLC_RST_OUT_OVW;
            uvw_q[c]   <= VLC_RST_OUT_UVW;
            uvf_q[c]   <= VLC_RST_OUT_UVF;
         end
      end else if (wr_any) begin
         unique case (req.code)
            // Set points ignored during rise and fall (see RULE18)
            VLC_OFS_OUT_NOM: begin
               if (phase[pg] != VLC_PH_RISE && phase[pg] != VLC_PH_FALL)
                  nom_q[pg] <= min16(req.data, VLC_RST_OUT_CEIL); // Clamp to ceiling (see RULE20, RULE22)
            end
            VLC_OFS_OUT_MHI: begin
               if (phase[pg] != VLC_PH_RISE && phase[pg] != VLC_PH_FALL)
                  mhi_q[pg] <= req.data; // see RULE16
            end
            VLC_OFS_OUT_MLO: begin
               if (phase[pg] != VLC_PH_RISE && phase[pg] != VLC_PH_FALL)
                  mlo_q[pg] <= req.data; // see RULE17
            end
            // Upper limit itself capped at 40.5 V (see RULE7)
            VLC_OFS_OUT_UPPER: upper_q[pg] <= min16(req.data, VLC_RST_OUT_CEIL);
            VLC_OFS_OUT_OVF:   ovf_q[pg]   <= min16(req.data, VLC_RST_OUT_CEIL); // see RULE8
            VLC_OFS_OUT_OVW:   ovw_q[pg]   <= req.data;
            VLC_OFS_OUT_UVW:   uvw_q[pg]   <= req.data;
            VLC_OFS_OUT_UVF:   uvf_q[pg]   <= req.data;
            default: ;         // Other codes not held here
         endcase
      end
   end

   // Shared input registers; filter value stored as given (see RULE5)
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         in_start_q <= VLC_RST_IN_START;
         in_stop_q  <= VLC_RST_IN_STOP;
         in_ovf_q   <= VLC_RST_IN_OVF;
         in_uvw_q   <= VLC_RST_IN_UVW;
         in_filt_q  <= VLC_RST_IN_FILT;
      end else if (wr_any) begin
         unique case (req.code)
            VLC_OFS_IN_START: in_start_q <= req.data;
            VLC_OFS_IN_STOP:  in_stop_q  <= req.data;
            VLC_OFS_IN_OVF:   in_ovf_q   <= req.data;
            VLC_OFS_IN_UVW:   in_uvw_q   <= req.data;
            VLC_OFS_IN_FILT:  in_filt_q  <= req.data;
            default: ;        // Output codes handled above
         endcase
      end
   end

   // Nominal above ceiling flags a communication fault (see RULE22)
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         cml_q     <= 1'b0;
         maxw_flag <= 2'b00;
      end else begin
         cml_q <= wr_any && req.code == VLC_OFS_OUT_NOM && req.data > VLC_RST_OUT_CEIL;
         for (int c = 0; c < 2; c++)
            if (wr_any && req.code == VLC_OFS_OUT_NOM && pg == c[0] && req.data > VLC_RST_OUT_CEIL)
               maxw_flag[c] <= 1'b1;
      end
   end

   // Read mux; the format byte and ceiling are fixed (see RULE6, RULE21)
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         rd_data  <= 16'h0000;
         rd_valid <= 1'b0;
      end else begin
         rd_valid <= req.rd;
         if (req.rd) begin
            unique case (req.code)
               VLC_OFS_OUT_FMT:   rd_data <= {8'h00, VLC_RST_OUT_FMT};
               VLC_OFS_OUT_NOM:   rd_data <= nom_q[pg];
               VLC_OFS_OUT_UPPER: rd_data <= upper_q[pg];
               VLC_OFS_OUT_MHI:   rd_data <= mhi_q[pg];
               VLC_OFS_OUT_MLO:   rd_data <= mlo_q[pg];
               VLC_OFS_OUT_OVF:   rd_data <= ovf_q[pg];
               VLC_OFS_OUT_OVW:   rd_data <= ovw_q[pg];
               VLC_OFS_OUT_UVW:   rd_data <= uvw_q[pg];
               VLC_OFS_OUT_UVF:   rd_data <= uvf_q[pg];
               VLC_OFS_OUT_CEIL:  rd_data <= VLC_RST_OUT_CEIL;
               VLC_OFS_IN_START:  rd_data <= in_start_q;
               VLC_OFS_IN_STOP:   rd_data <= in_stop_q;
               VLC_OFS_IN_OVF:    rd_data <= in_ovf_q;
               VLC_OFS_IN_UVW:    rd_data <= in_uvw_q;
               VLC_OFS_IN_FILT:   rd_data <= in_filt_q;
               default:           rd_data <= 16'h0000; // Unknown code reads zero
            endcase
         end
      end
   end

   // Start and stop thresholds with hysteresis (see RULE4)
   always_ff @(posedge clk or posedge rst) begin
      if (rst)
         conv_q <= 1'b0;
      else if (!conv_q && !l11_gt(in_start_q, vin_meas))
         conv_q <= 1'b1;
      else if (conv_q && !l11_gt(vin_meas, in_stop_q))
         conv_q <= 1'b0;
   end

   // Arm input warning after start reached and unit enabled (see RULE2)
   always_ff @(posedge clk or posedge rst) begin
      if (rst)
         uv_arm_q <= 2'b00;
      else
         for (int c = 0; c < 2; c++)
            uv_arm_q[c] <= run_en[c] && (uv_arm_q[c] || (conv_q && !l11_gt(in_start_q, vin_meas)));
   end

   // Input fault and warning flags, sticky until reset (see RULE1, RULE3)
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         in_ovf_flag <= 1'b0;
         in_uvw_flag <= 1'b0;
      end else begin
         if (l11_gt(vin_meas, in_ovf_q))
            in_ovf_flag <= 1'b1; // see RULE1
         if (|uv_arm_q && l11_gt(in_uvw_q, vin_meas))
            in_uvw_flag <= 1'b1; // see RULE3
      end
   end

   // Busy after fault threshold change while running (see RULE10)
   always_ff @(posedge clk or posedge rst) begin
      if (rst)
         busy_cnt_q <= 32'h0;
      else if (wr_any && req.code == VLC_OFS_OUT_OVF && phase[pg] != VLC_PH_OFF)
         busy_cnt_q <= 32'(OVF_SETTLE_CYC);
      else if (busy_cnt_q != 32'h0)
         busy_cnt_q <= busy_cnt_q - 32'h1;
   end

   // Output warnings sampled once per ADC interval, bounding latency (see RULE15)
   always_ff @(posedge clk or posedge rst) begin
      if (rst)
         ovw_cnt_q <= 32'h0;
      else if (ovw_cnt_q == 32'(OVW_DETECT_CYC - 1))
         ovw_cnt_q <= 32'h0;
      else
         ovw_cnt_q <= ovw_cnt_q + 32'h1;
   end

   // Output fault and warning flags per channel
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         ovf_q_flag <= 2'b00;
         ovw_flag   <= 2'b00;
         uvw_flag   <= 2'b00;
      end else begin
         for (int c = 0; c < 2; c++) begin
            if (meas[c].ovf_cmp)
               ovf_q_flag[c] <= 1'b1; // see RULE8
            if (ovw_cnt_q == 32'h0 && meas[c].vout_peak > ovw_q[c])
               ovw_flag[c] <= 1'b1;   // see RULE13
            if (ovw_cnt_q == 32'h0 && phase[c] == VLC_PH_STEADY && meas[c].vout_avg < uvw_q[c])
               uvw_flag[c] <= 1'b1;   // see RULE23
         end
      end
   end

   // Gate override on overvoltage, comparator acts on the next edge (see RULE12)
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         high_side_gate_drive <= 2'b00;
         low_side_gate_drive  <= 2'b00;
         fault_pin_n          <= 2'b11;
      end else begin
         for (int c = 0; c < 2; c++) begin
            high_side_gate_drive[c] <= conv_q && run_en[c] && !meas[c].ovf_cmp && !ovf_q_flag[c];
            low_side_gate_drive[c]  <= meas[c].ovf_cmp || ovf_q_flag[c];
            // Pull-down response keeps pin released (see RULE11)
            fault_pin_n[c] <= !(ovf_q_flag[c] && !ov_pd_response[c]);
         end
      end
   end

   // Target selection, clamp and ramp (see RULE7, RULE16, RULE17, RULE19)
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         tgt_q <= {VLC_RST_OUT_NOM, VLC_RST_OUT_NOM};
      end else begin
         for (int c = 0; c < 2; c++) begin
            logic [15:0] want;
            want = (op_sel[c] == VLC_OP_MHIGH) ? mhi_q[c] :
                   (op_sel[c] == VLC_OP_MLOW)  ? mlo_q[c] : nom_q[c];
            want = min16(want, upper_q[c]); // see RULE7
            if (phase[c] != VLC_PH_STEADY)
               tgt_q[c] <= want;            // Jump outside steady state
            else if (rate_tick && tgt_q[c] < want)
               tgt_q[c] <= (want - tgt_q[c] > STEP) ? tgt_q[c] + STEP : want; // see RULE19
            else if (rate_tick && tgt_q[c] > want)
               tgt_q[c] <= (tgt_q[c] - want > STEP) ? tgt_q[c] - STEP : want;
         end
      end
   end

   // Status registers and alert (see RULE3, RULE14, RULE23)
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         status_byte  <= 8'h00;
         status_word  <= 16'h0000;
         status_input <= 8'h00;
         status_vout  <= '0;
         alert_n      <= 1'b1;
         communication_fault    <= 1'b0;
         common_status_register <= 8'hff;
         convert_on   <= 1'b0;
         vout_target  <= '0;
      end else begin
         status_input <= 8'((8'(in_ovf_flag) << VLC_SI_IN_OVF) | (8'(in_uvw_flag) << VLC_SI_IN_UVW));
         for (int c = 0; c < 2; c++)
            status_vout[c] <= 8'((8'(ovf_q_flag[c]) << VLC_SV_OVF) | (8'(ovw_flag[c]) << VLC_SV_OVW) |
                                 (8'(uvw_flag[c]) << VLC_SV_UVW) | (8'(maxw_flag[c]) << VLC_SV_MAXW));
         status_byte <= 8'(8'(|ovw_flag || |uvw_flag) << VLC_SB_NONE_ABOVE);
         status_word <= 16'((16'(in_uvw_flag || in_ovf_flag) << VLC_SW_INPUT) |
                            (16'(|ovw_flag || |uvw_flag || |ovf_q_flag || |maxw_flag) << VLC_SW_VOUT));
         alert_n <= !(((in_uvw_flag || in_ovf_flag) && !alert_mask[0]) ||
                      ((|ovw_flag || |uvw_flag || |ovf_q_flag || |maxw_flag) && !alert_mask[1]));
         communication_fault <= cml_q;
         common_status_register[VLC_CS_IDLE_A] <= busy_cnt_q == 32'h0; // see RULE10
         common_status_register[VLC_CS_IDLE_B] <= busy_cnt_q == 32'h0;
         convert_on  <= conv_q;
         vout_target <= tgt_q;
      end
   end

endmodule

/* File: rtl/vlc_pkg.sv */
// Shared constants and types for the voltage limit command bank
package vlc_pkg;

   // Command codes of the bank
   localparam logic [7:0] VLC_OFS_OUT_FMT   = 8'h20;
   localparam logic [7:0] VLC_OFS_OUT_NOM   = 8'h21;
   localparam logic [7:0] VLC_OFS_OUT_UPPER = 8'h24;
   localparam logic [7:0] VLC_OFS_OUT_MHI   = 8'h25;
   localparam logic [7:0] VLC_OFS_OUT_MLO   = 8'h26;
   localparam logic [7:0] VLC_OFS_IN_START  = 8'h35;
   localparam logic [7:0] VLC_OFS_IN_STOP   = 8'h36;
   localparam logic [7:0] VLC_OFS_OUT_OVF   = 8'h40;
   localparam logic [7:0] VLC_OFS_OUT_OVW   = 8'h42;
   localparam logic [7:0] VLC_OFS_OUT_UVW   = 8'h43;
   localparam logic [7:0] VLC_OFS_OUT_UVF   = 8'h44;
   localparam logic [7:0] VLC_OFS_IN_OVF    = 8'h55;
   localparam logic [7:0] VLC_OFS_IN_UVW    = 8'h58;
   localparam logic [7:0] VLC_OFS_OUT_CEIL  = 8'ha5;
   localparam logic [7:0] VLC_OFS_IN_FILT   = 8'hf7;

   // Reset values
   localparam logic [7:0]  VLC_RST_OUT_FMT   = 8'h16;
   localparam logic [15:0] VLC_RST_OUT_NOM   = 16'h1400;
   localparam logic [15:0] VLC_RST_OUT_UPPER = 16'ha000;
   localparam logic [15:0] VLC_RST_OUT_MHI   = 16'h1500;
   localparam logic [15:0] VLC_RST_OUT_MLO   = 16'h1300;
   localparam logic [15:0] VLC_RST_IN_START  = 16'hcb40;
   localparam logic [15:0] VLC_RST_IN_STOP   = 16'hcb00;
   localparam logic [15:0] VLC_RST_OUT_OVF   = 16'h1600;
   localparam logic [15:0] VLC_RST_OUT_OVW   = 16'h1580;
   localparam logic [15:0] VLC_RST_OUT_UVW   = 16'h1280;
   localparam logic [15:0] VLC_RST_OUT_UVF   = 16'h1200;
   localparam logic [15:0] VLC_RST_IN_OVF    = 16'he300;
   localparam logic [15:0] VLC_RST_IN_UVW    = 16'hcb26;
   localparam logic [15:0] VLC_RST_OUT_CEIL  = 16'ha200;
   localparam logic [15:0] VLC_RST_IN_FILT   = 16'h0be8;

   // Field positions of the output format byte
   localparam int VLC_FMT_EXP_LSB  = 0;
   localparam int VLC_FMT_EXP_MSB  = 4;
   localparam int VLC_FMT_MODE_LSB = 5;
   localparam int VLC_FMT_MODE_MSB = 7;

   // Status bit positions
   localparam int VLC_SB_NONE_ABOVE = 0;  // Status byte
   localparam int VLC_SW_INPUT      = 13; // Status word
   localparam int VLC_SW_VOUT       = 15;
   localparam int VLC_SI_IN_OVF     = 7;  // Input status
   localparam int VLC_SI_IN_UVW     = 5;
   localparam int VLC_SV_OVF        = 7;  // Output status
   localparam int VLC_SV_OVW        = 6;
   localparam int VLC_SV_UVW        = 5;
   localparam int VLC_SV_UVF        = 4;
   localparam int VLC_SV_MAXW       = 3;
   localparam int VLC_CS_IDLE_A     = 5;  // Common status
   localparam int VLC_CS_IDLE_B     = 6;

   // Timing in its own units and clock rate
   localparam int VLC_CLK_MHZ       = 250;
   localparam int VLC_OVF_SETTLE_MS = 10;
   localparam int VLC_OVW_DETECT_MS = 120;
   localparam int VLC_OVF_SETTLE_CYC = VLC_OVF_SETTLE_MS * 1000 * VLC_CLK_MHZ;
   localparam int VLC_OVW_DETECT_CYC = VLC_OVW_DETECT_MS * 1000 * VLC_CLK_MHZ;

   // Operation selection of the set point
   typedef enum logic [1:0] {
      VLC_OP_NOMINAL = 2'b00,
      VLC_OP_MLOW    = 2'b01,
      VLC_OP_MHIGH   = 2'b10
   } vlc_op_type;

   // Channel sequencing phase
   typedef enum logic [1:0] {
      VLC_PH_OFF    = 2'b00,
      VLC_PH_RISE   = 2'b01,
      VLC_PH_STEADY = 2'b10,
      VLC_PH_FALL   = 2'b11
   } vlc_phase_type;

   // Register access request
   typedef struct packed {
      logic        wr;
      logic        rd;
      logic        page;
      logic [7:0]  code;
      logic [15:0] data;
   } vlc_req_type;

   // Per-channel measurements
   typedef struct packed {
      logic [15:0] vout_peak;
      logic [15:0] vout_avg;
      logic        ovf_cmp;
   } vlc_meas_type;

endpackage

/* File: verification/vlc_bank_asserts.sv */
// Concurrent checks on the limit command bank ports
`timescale 1ns/1ps
module vlc_bank_asserts
   import vlc_pkg::*;
(
   input wire logic                clk,
   input wire logic                rst,
   input wire vlc_req_type         req,
   input wire logic                rd_valid,
   input wire vlc_meas_type [1:0]  meas,
   input wire vlc_phase_type [1:0] phase,
   input wire logic [1:0]          ov_pd_response,
   input wire logic [1:0]          alert_mask,
   input wire logic [1:0]          high_side_gate_drive,
   input wire logic [1:0]          low_side_gate_drive,
   input wire logic [1:0]          fault_pin_n,
   input wire logic                alert_n,
   input wire logic                communication_fault,
   input wire logic [7:0]          status_byte,
   input wire logic [15:0]         status_word,
   input wire logic [7:0]          status_input,
   input wire logic [1:0][7:0]     status_vout,
   input wire logic [1:0][15:0]    vout_target,
   input wire logic [7:0]          common_status_register
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   // Every read is answered on the next edge, and only then
   rd_answer_a: assert property (req.rd |=> rd_valid)
      else $error("read not answered");
   rd_quiet_a: assert property (!req.rd |=> !rd_valid)
      else $error("stray read strobe");
   // Comparator trip on channel 0 forces the gates within one to two edges
   ov_gate_a: assert property (meas[0].ovf_cmp |-> ##[1:2] (!high_side_gate_drive[0] && low_side_gate_drive[0]))
      else $error("gates not forced on overvoltage");
   ov_flag_a: assert property (meas[1].ovf_cmp |-> ##[1:2] status_vout[1][VLC_SV_OVF])
      else $error("overvoltage fault flag missing");
   // Pull-down response on channel 0 keeps the channel 0 pin quiet whatever happens
   pd_quiet_a: assert property (ov_pd_response[0] |-> fault_pin_n[0])
      else $error("fault pin asserted under pull-down response");
   ceil_cml_a: assert property (req.wr && req.code == VLC_OFS_OUT_NOM && req.data > VLC_RST_OUT_CEIL
      && !phase[req.page][0] |-> ##2 communication_fault) else $error("no fault on set point above ceiling");
   ovw_bits_a: assert property (status_vout[0][VLC_SV_OVW] |-> ##[0:1]
      (status_byte[VLC_SB_NONE_ABOVE] && status_word[VLC_SW_VOUT])) else $error("warning summary bits missing");
   vout_alert_a: assert property (status_word[VLC_SW_VOUT] && !alert_mask[1] |-> ##[0:2] !alert_n)
      else $error("alert not raised for output group");
   uvw_word_a: assert property (status_input[VLC_SI_IN_UVW] |-> ##[0:1] status_word[VLC_SW_INPUT])
      else $error("input bit of status word missing");
   // Only the two busy bits may ever drop
   cs_idle_a: assert property ((common_status_register | 8'h60) == 8'hff)
      else $error("common status stray bit low");
   target_cap_a: assert property (vout_target[0] <= VLC_RST_OUT_CEIL)
      else $error("target above ceiling");
   cover property (communication_fault);
   cover property (!alert_n);
   cover property (common_status_register[6:5] != 2'b11);
endmodule

/* File: verification/vlc_host.sv */
// Host model issuing register commands to the bank
`timescale 1ns/1ps
module vlc_host
   import vlc_pkg::*;
(
   input  wire logic        clk,
   output vlc_req_type      req,
   input  wire logic [15:0] rd_data,
   input  wire logic        rd_valid
);
   initial req = '0;
   // One-cycle write strobe, taken at the next rising edge
   task automatic wr(input logic pg, input logic [7:0] cd, input logic [15:0] dt);
      @(negedge clk);
      req <= '{wr: 1'b1, rd: 1'b0, page: pg, code: cd, data: dt};
      @(negedge clk);
      req.wr <= 1'b0;
   endtask
   // Read; answer is registered one edge after the request
   task automatic rd(input logic pg, input logic [7:0] cd, output logic [15:0] dt);
      @(negedge clk);
      req <= '{wr: 1'b0, rd: 1'b1, page: pg, code: cd, data: 16'h0000};
      @(negedge clk);
      req.rd <= 1'b0;
      dt = rd_valid ? rd_data : 16'hxxxx;
   endtask
endmodule

/* File: verification/tb.sv */
// Self-checking bench for the limit command bank
`timescale 1ns/1ps
module tb;
   import vlc_pkg::*;
   logic clk = 1'b0;
   logic rst = 1'b1;
   vlc_req_type req;
   logic [15:0] rd_data, vin_meas, status_word, v;
   logic rd_valid, rate_tick, convert_on, alert_n, communication_fault;
   vlc_meas_type [1:0] meas;
   logic [1:0] run_en, ov_pd_response, alert_mask, high_side_gate_drive, low_side_gate_drive, fault_pin_n;
   vlc_op_type [1:0] op_sel;
   vlc_phase_type [1:0] phase;
   logic [1:0][15:0] vout_target;
   logic [7:0] status_byte, status_input, common_status_register;
   logic [1:0][7:0] status_vout;
   int error_cnt = 0;
   int total_checks = 0;
   // Code and reset value of every register
   logic [23:0] rv [15] = '{24'h200016, 24'h211400, 24'h24a000, 24'h251500, 24'h261300, 24'h35cb40,
      24'h36cb00, 24'h401600, 24'h421580, 24'h431280, 24'h441200, 24'h55e300, 24'h58cb26, 24'ha5a200, 24'hf70be8};
   always #2 clk = ~clk;
   vlc_host i_vlc_host (.clk, .req, .rd_data, .rd_valid);
   // Short counts keep busy and warning waits brief
   vlc_bank #(.OVF_SETTLE_CYC(20), .OVW_DETECT_CYC(8), .RAMP_STEP(1)) i_vlc_bank (.clk, .rst, .req, .rd_data,
      .rd_valid, .vin_meas, .meas, .run_en, .op_sel, .ov_pd_response, .alert_mask, .rate_tick, .phase,
      .convert_on, .vout_target, .high_side_gate_drive, .low_side_gate_drive, .fault_pin_n, .alert_n,
      .communication_fault, .status_byte, .status_word, .status_input, .status_vout, .common_status_register);
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      total_checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic rchk(input logic pg, input logic [7:0] cd, input logic [15:0] exp);
      i_vlc_host.rd(pg, cd, v);
      check(v, exp);
   endtask
   task automatic cyc(input int n);
      repeat (n) @(negedge clk);
   endtask
   task automatic results();
      $display("checks %0d errors %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   // Watchdog well beyond the roughly 990 cycles of the tests
   initial begin
      #80000;
      error_cnt++;
      results();
   end
   initial begin
      vin_meas = 16'hcb10;
      meas = {2{16'h1400, 16'h1400, 1'b0}};
      run_en = 2'b11;
      op_sel = '{VLC_OP_NOMINAL, VLC_OP_NOMINAL};
      ov_pd_response = 2'b01;
      alert_mask = 2'b01;
      rate_tick = 1'b1;
      phase = '{VLC_PH_RISE, VLC_PH_STEADY};
      cyc(5);
      rst = 1'b0;
      foreach (rv[i]) rchk(1'b0, rv[i][23:16], rv[i][15:0]);
      rchk(1'b0, 8'h30, 16'h0000);
      i_vlc_host.wr(1'b0, 8'h20, 16'h0000);
      i_vlc_host.wr(1'b0, 8'ha5, 16'h0000);
      rchk(1'b0, 8'h20, 16'h0016);
      rchk(1'b0, 8'ha5, 16'ha200);
      // Paged output words, shared input words
      i_vlc_host.wr(1'b1, 8'h24, 16'h9000);
      rchk(1'b0, 8'h24, 16'ha000);
      rchk(1'b1, 8'h24, 16'h9000);
      check(vout_target[1], 16'h1400);
      i_vlc_host.wr(1'b1, 8'h55, 16'he200);
      rchk(1'b0, 8'h55, 16'he200);
      // Channel 1 is rising, so set point writes are dropped
      i_vlc_host.wr(1'b1, 8'h21, 16'h1234);
      rchk(1'b1, 8'h21, 16'h1400);
      i_vlc_host.wr(1'b0, 8'hf7, 16'h0000);
      rchk(1'b0, 8'hf7, 16'h0000);
      // Input never above start yet: warning stays off
      cyc(20);
      check(status_input[5], 16'h0000);
      check(convert_on, 16'h0000);
      vin_meas = 16'hcb80;
      cyc(20);
      check(convert_on, 16'h0001);
      vin_meas = 16'hcb10;
      cyc(20);
      check(status_input[5], 16'h0001);
      check(status_word[13], 16'h0001);
      check(alert_n, 16'h0001);
      check(convert_on, 16'h0001);
      vin_meas = 16'hcaf0;
      cyc(20);
      check(convert_on, 16'h0000);
      vin_meas = 16'hcb80;
      rate_tick = 1'b0;
      i_vlc_host.wr(1'b0, 8'h21, 16'h1402);
      cyc(12);
      check(vout_target[0], 16'h1400);
      rate_tick = 1'b1;
      cyc(12);
      check(vout_target[0], 16'h1402);
      i_vlc_host.wr(1'b0, 8'h40, 16'h1700);
      cyc(2);
      check(&common_status_register[6:5], 16'h0000);
      cyc(25);
      check(&common_status_register[6:5], 16'h0001);
      // Margin high sits above nominal, low below
      i_vlc_host.wr(1'b0, 8'h24, 16'h1480);
      op_sel[0] = VLC_OP_MHIGH;
      cyc(300);
      check(vout_target[0], 16'h1480);
      op_sel[0] = VLC_OP_MLOW;
      cyc(420);
      check(vout_target[0], 16'h1300);
      op_sel[0] = VLC_OP_NOMINAL;
      meas[0].vout_peak = 16'h1600;
      cyc(20);
      check(status_vout[0][6], 16'h0001);
      check({status_byte[0], status_word[15], alert_n}, 16'h0006);
      i_vlc_host.wr(1'b0, 8'h21, 16'ha300);
      cyc(4);
      check(status_vout[0][3], 16'h0001);
      phase[1] = VLC_PH_STEADY;
      meas[1].vout_avg = 16'h1200;
      cyc(20);
      check(status_vout[1][5], 16'h0001);
      vin_meas = 16'he310;
      cyc(20);
      check(status_input[7], 16'h0001);
      meas[0].ovf_cmp = 1'b1;
      meas[1].ovf_cmp = 1'b1;
      cyc(3);
      check({high_side_gate_drive, low_side_gate_drive}, 16'h0003);
      check(fault_pin_n, 16'h0001);
      check(status_vout[1][7], 16'h0001);
      results();
   end
endmodule
bind vlc_bank vlc_bank_asserts i_vlc_bank_asserts (.clk, .rst, .req, .rd_valid, .meas, .phase, .ov_pd_response,
   .alert_mask, .high_side_gate_drive, .low_side_gate_drive, .fault_pin_n, .alert_n, .communication_fault,
   .status_byte, .status_word, .status_input, .status_vout, .vout_target, .common_status_register);
